/* verilog/scct_pkg.sv */
// constants for the speech control configuration and countdown timer block
package scct_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CFG1 = 6'h12;
  localparam logic [5:0] IDX_CFG2 = 6'h13;
  localparam logic [5:0] IDX_CFG3 = 6'h14;
  localparam logic [5:0] IDX_CFG4 = 6'h15;
  localparam logic [5:0] IDX_TIM_HI = 6'h3b;
  localparam logic [5:0] IDX_TIM_LO = 6'h3c;
  localparam logic [5:0] IDX_CTRL = 6'h3d;
  localparam logic [5:0] IDX_STATUS = 6'h3e;
  localparam logic [5:0] IDX_COUNT = 6'h3f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CFG1 = 8'h69;
  localparam logic [7:0] RST_CFG2 = 8'h97;
  localparam logic [7:0] RST_CFG3 = 8'ha4;
  localparam logic [7:0] RST_CFG4 = 8'ha7;
  localparam logic [7:0] RST_TIM = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WP_RELEASE_BIT = 1;
  localparam int STAT_EXPIRED_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int CFG3_COEFF_CONTROL_MIN_LEVEL_LSB = 3;
  localparam int CFG3_DOUBLE_TALK_HANGOVER_LSB = 1;
  localparam int CFG3_CRIT_BIT = 0;

  // ----------------------------------------------------------------
  // timing and scales
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_PERIOD_PS = 1000000000;
  localparam int MS_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [8:0] HANGOVER_BASE_MS = 9'h020;
  localparam logic [6:0] DT_ITU_MIN_LOSS_DB = 7'h06;

endpackage

/* verilog/scct_timer_if.sv */
// carrier between the register bank and the millisecond countdown
`timescale 1ns/1ps
`default_nettype none
interface scct_timer_if;
  logic [15:0] load_value;
  logic run;
  logic clr_expired;
  logic [15:0] count;
  logic expired;
  logic active;

  modport ctl (output load_value, output run, output clr_expired,
               input count, input expired, input active);
  modport tmr (input load_value, input run, input clr_expired,
               output count, output expired, output active);
endinterface
`default_nettype wire

/* verilog/scct_timer.sv */
// millisecond countdown timer
`timescale 1ns/1ps
`default_nettype none
module scct_timer #(
  parameter int MS_CYCLES = scct_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register side
  scct_timer_if.tmr tif
);

  logic run_prev_q;
  logic [31:0] div_q;
  logic [15:0] cnt_q;
  logic exp_q;
  wire start = tif.run & ~run_prev_q;
  wire counting = tif.run & ~start & (cnt_q != 16'h0000);
  wire tick = counting & (div_q == 32'(MS_CYCLES - 1));
  wire hit_zero = (start & (tif.load_value == 16'h0000)) | (tick & (cnt_q == 16'h0001));

  // ----------------------------------------------------------------
  // prescaler and count, restarted on each start
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_prev_q <= 1'b0;
      div_q <= 32'h0;
      cnt_q <= 16'h0000;
    end else begin
      run_prev_q <= tif.run;
      if (start) begin
        div_q <= 32'h0;
        cnt_q <= tif.load_value;
      end else if (tick) begin
        div_q <= 32'h0;
        cnt_q <= cnt_q - 16'h0001;
      end else if (counting) begin
        div_q <= div_q + 32'h1;
      end
    end
  end

  // expiry is sticky; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_q <= 1'b0;
    end else begin
      exp_q <= hit_zero | (exp_q & ~tif.clr_expired);
    end
  end

  assign tif.count = cnt_q;
  assign tif.expired = exp_q;
  assign tif.active = tif.run & (cnt_q != 16'h0000);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [31:0] elapsed_q;
  logic [15:0] loaded_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_q <= 32'h0;
      loaded_q <= 16'h0000;
    end else if (start) begin
      elapsed_q <= 32'h0;
      loaded_q <= tif.load_value;
    end else if (tif.run) begin
      elapsed_q <= elapsed_q + 32'h1;
    end
  end
  wire [31:0] due_cycles = 32'(loaded_q) * 32'(MS_CYCLES);

  a_timer_load: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> cnt_q == $past(tif.load_value))
    else $error("count not loaded from the two load bytes");
  a_ms_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tif.run && !$past(start) && cnt_q != $past(cnt_q)) |-> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("count moved by other than one");
  a_expiry_window: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(exp_q) && !$past(start)) |-> elapsed_q == due_cycles)
    else $error("expiry not at the programmed millisecond");
  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!tif.run && !$past(tif.run)) |-> $stable(cnt_q))
    else $error("count moved while stopped");
  a_no_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_q == 16'h0000 && !start) |=> cnt_q == 16'h0000)
    else $error("count wrapped below zero");
  c_expiry: cover property (@(posedge pclk) disable iff (!presetn)
    tif.run && $rose(exp_q));
  c_stop_mid: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(tif.run) && cnt_q != 16'h0000);

endmodule // scct_timer
`default_nettype wire

/* verilog/scct_regbank.sv */
// speech control configuration registers and host countdown timer over APB
`timescale 1ns/1ps
`default_nettype none
module scct_regbank #(
  parameter int MS_CYCLES = scct_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measured levels from the datapath
  input wire logic [4:0] send_input_level,
  input wire logic [4:0] receive_input_level,
  input wire logic [6:0] transhybrid_loss_db,
  // configuration to the speech control unit
  output logic [3:0] noise_safety_margin,
  output logic [1:0] fast_meter_period,
  output logic [1:0] slow_meter_period,
  output logic [4:0] canceller_bypass_threshold,
  output logic [1:0] echo_safety_margin,
  output logic high_hybrid_detect_enable,
  output logic [4:0] coeff_control_min_level,
  output logic [1:0] double_talk_hangover,
  output logic double_talk_criterion,
  output logic [7:0] speech_ctrl_config_4,
  output logic [8:0] hangover_ms,
  output logic coeff_adapt_permit,
  output logic double_talk_allowed,
  // timer status
  output logic timer_expired
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] cfg3_q;
  logic [7:0] cfg4_q;
  logic [7:0] tim_hi_q;
  logic [7:0] tim_lo_q;
  logic run_q;
  logic wp_release_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  scct_timer_if tif ();

  scct_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire [5:0] idx = paddr[7:2];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire lane0 = pstrb[0];
  wire hit_cfg1 = (idx == scct_pkg::IDX_CFG1);
  wire hit_cfg2 = (idx == scct_pkg::IDX_CFG2);
  wire hit_cfg3 = (idx == scct_pkg::IDX_CFG3);
  wire hit_cfg4 = (idx == scct_pkg::IDX_CFG4);
  wire hit_cfg = hit_cfg1 | hit_cfg2 | hit_cfg3 | hit_cfg4;
  wire hit_hi = (idx == scct_pkg::IDX_TIM_HI);
  wire hit_lo = (idx == scct_pkg::IDX_TIM_LO);
  wire hit_ctrl = (idx == scct_pkg::IDX_CTRL);
  wire hit_stat = (idx == scct_pkg::IDX_STATUS);
  wire hit_cnt = (idx == scct_pkg::IDX_COUNT);
  wire mapped = hit_cfg | hit_hi | hit_lo | hit_ctrl | hit_stat | hit_cnt;
  wire aligned = (paddr[1:0] == 2'b00);
  // locked configuration writes are refused with an error
  wire locked_wr = pwrite & hit_cfg & ~wp_release_q;
  wire err = ~mapped | ~aligned | locked_wr;
  wire wr = access & pwrite & ~pslverr_q & lane0;
  wire cfg_wr = wr & wp_release_q;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_q <= scct_pkg::RST_CFG1;
      cfg2_q <= scct_pkg::RST_CFG2;
      cfg3_q <= scct_pkg::RST_CFG3;
      cfg4_q <= scct_pkg::RST_CFG4;
    end else begin
      if (cfg_wr && hit_cfg1) begin
        cfg1_q <= pwdata[7:0];
      end
      if (cfg_wr && hit_cfg2) begin
        cfg2_q <= pwdata[7:0];
      end
      if (cfg_wr && hit_cfg3) begin
        cfg3_q <= pwdata[7:0];
      end
      if (cfg_wr && hit_cfg4) begin
        cfg4_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tim_hi_q <= scct_pkg::RST_TIM;
      tim_lo_q <= scct_pkg::RST_TIM;
      run_q <= 1'b0;
      wp_release_q <= 1'b0;
    end else begin
      if (wr && hit_hi) begin
        tim_hi_q <= pwdata[7:0];
      end
      if (wr && hit_lo) begin
        tim_lo_q <= pwdata[7:0];
      end
      if (wr && hit_ctrl) begin
        run_q <= pwdata[scct_pkg::CTRL_RUN_BIT];
        wp_release_q <= pwdata[scct_pkg::CTRL_WP_RELEASE_BIT];
      end
    end
  end

  // expiry flag is write-one-to-clear in the status word
  assign tif.clr_expired = wr & hit_stat & pwdata[scct_pkg::STAT_EXPIRED_BIT];
  assign tif.load_value = {tim_hi_q, tim_lo_q};
  assign tif.run = run_q;

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (1'b1)
      hit_cfg1: rd_mux = {24'h0, cfg1_q};
      hit_cfg2: rd_mux = {24'h0, cfg2_q};
      hit_cfg3: rd_mux = {24'h0, cfg3_q};
      hit_cfg4: rd_mux = {24'h0, cfg4_q};
      hit_hi: rd_mux = {24'h0, tim_hi_q};
      hit_lo: rd_mux = {24'h0, tim_lo_q};
      hit_ctrl: rd_mux = {30'h0, wp_release_q, run_q};
      hit_stat: rd_mux = {30'h0, tif.active, tif.expired};
      hit_cnt: rd_mux = {16'h0, tif.count};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= (pwrite || err) ? 32'h0 : rd_mux;
      pslverr_q <= err;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access & pslverr_q;

  // ----------------------------------------------------------------
  // configuration fields and decoded controls
  // ----------------------------------------------------------------
  assign noise_safety_margin = cfg1_q[7:4];
  assign fast_meter_period = cfg1_q[3:2];
  assign slow_meter_period = cfg1_q[1:0];
  assign canceller_bypass_threshold = cfg2_q[7:3];
  assign echo_safety_margin = cfg2_q[2:1];
  assign high_hybrid_detect_enable = cfg2_q[0];
  assign coeff_control_min_level = cfg3_q[scct_pkg::CFG3_COEFF_CONTROL_MIN_LEVEL_LSB +: 5];
  assign double_talk_hangover = cfg3_q[scct_pkg::CFG3_DOUBLE_TALK_HANGOVER_LSB +: 2];
  assign double_talk_criterion = cfg3_q[scct_pkg::CFG3_CRIT_BIT];
  assign speech_ctrl_config_4 = cfg4_q;
  assign timer_expired = tif.expired;

  // level codes share one scale: code n is -69 dBm0 plus n times 1.5 dB
  function automatic logic level_ok(input logic [4:0] lvl, input logic [4:0] min_lvl);
    level_ok = (lvl >= min_lvl);
  endfunction

  wire no_floor = (coeff_control_min_level == 5'h00);
  assign coeff_adapt_permit = no_floor |
    (level_ok(send_input_level, coeff_control_min_level) &
     level_ok(receive_input_level, coeff_control_min_level));
  assign hangover_ms = scct_pkg::HANGOVER_BASE_MS << double_talk_hangover;
  assign double_talk_allowed = ~double_talk_criterion |
    (transhybrid_loss_db >= scct_pkg::DT_ITU_MIN_LOSS_DB);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_cfg_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit_cfg3 && !wp_release_q) |=> $stable(cfg3_q))
    else $error("locked configuration register changed");
  a_cfg_unlocked: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit_cfg2 && wp_release_q && lane0 && aligned)
      |=> cfg2_q == $past(pwdata[7:0]))
    else $error("unlocked configuration write lost");
  a_min_level: assert property (@(posedge pclk) disable iff (!presetn)
    (coeff_control_min_level != 5'h00 && send_input_level < coeff_control_min_level)
      |-> !coeff_adapt_permit)
    else $error("adaptation permitted below minimum level");
  a_no_floor: assert property (@(posedge pclk) disable iff (!presetn)
    (coeff_control_min_level == 5'h00) |-> coeff_adapt_permit)
    else $error("level floor active with code zero");
  a_hangover_map: assert property (@(posedge pclk) disable iff (!presetn)
    (double_talk_hangover == 2'b11) |-> hangover_ms == 9'h100)
    else $error("hangover code three not 256 ms");
  a_dt_open: assert property (@(posedge pclk) disable iff (!presetn)
    !double_talk_criterion |-> double_talk_allowed)
    else $error("double talk blocked without criterion");
  a_dt_itu: assert property (@(posedge pclk) disable iff (!presetn)
    (double_talk_criterion && transhybrid_loss_db == 7'h05) |-> !double_talk_allowed)
    else $error("double talk allowed below 6 dB");
  a_run_start: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && hit_ctrl && lane0 && aligned && pwdata[0] && !run_q)
      |=> ##1 tif.count == {tim_hi_q, tim_lo_q})
    else $error("run bit did not start the countdown");
  c_locked_write: cover property (@(posedge pclk) disable iff (!presetn)
    access && locked_wr);
  c_unlock_write: cover property (@(posedge pclk) disable iff (!presetn)
    cfg_wr && hit_cfg3);
  c_itu_block: cover property (@(posedge pclk) disable iff (!presetn)
    double_talk_criterion && !double_talk_allowed);

endmodule // scct_regbank
`default_nettype wire

/* verification/scct_host_model.sv */
// host processor model driving the apb register port
`timescale 1ns/1ps
`default_nettype none
module scct_host_model (
  // clock
  input wire logic pclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // wait limit used up
  output logic hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    hung = 1'b0;
  end

  // one transfer: setup, then access until pready at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    hung <= (n >= 64);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines no longer show the last value
    paddr <= ~a;
    pwdata <= ~d;
    pstrb <= ~s;
  endtask
endmodule // scct_host_model
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the speech control registers and countdown timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int MSC = 8;
  typedef struct {
    logic [7:0] cfg;
    logic [4:0] si;
    logic [4:0] ri;
    logic [6:0] loss;
    logic permit;
    logic allowed;
    logic [8:0] hang;
  } scct_row_s;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [4:0] send_input_level, receive_input_level, canceller_bypass_threshold;
  logic [6:0] transhybrid_loss_db;
  logic [3:0] noise_safety_margin;
  logic [1:0] fast_meter_period, slow_meter_period, echo_safety_margin, double_talk_hangover;
  logic high_hybrid_detect_enable, double_talk_criterion, coeff_adapt_permit;
  logic double_talk_allowed, timer_expired;
  logic [4:0] coeff_control_min_level;
  logic [7:0] speech_ctrl_config_4;
  logic [8:0] hangover_ms;
  int err_total, n_checks;
  logic [5:0] ridx [6] = '{scct_pkg::IDX_CFG1, scct_pkg::IDX_CFG2, scct_pkg::IDX_CFG3,
                           scct_pkg::IDX_CFG4, scct_pkg::IDX_TIM_HI, scct_pkg::IDX_TIM_LO};
  logic [7:0] rval [6] = '{8'h69, 8'h97, 8'ha4, 8'ha7, 8'h00, 8'h00};
  scct_row_s rows [5] = '{
    '{8'h00, 5'h00, 5'h00, 7'h00, 1'b1, 1'b1, 9'h020},
    '{8'h0b, 5'h01, 5'h01, 7'h06, 1'b1, 1'b1, 9'h040},
    '{8'h0d, 5'h00, 5'h05, 7'h05, 1'b0, 1'b0, 9'h080},
    '{8'hfe, 5'h1f, 5'h1e, 7'h00, 1'b0, 1'b1, 9'h100},
    '{8'hf9, 5'h1f, 5'h1f, 7'h07, 1'b1, 1'b1, 9'h020}};

  scct_regbank #(.MS_CYCLES(MSC)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .send_input_level, .receive_input_level, .transhybrid_loss_db,
    .noise_safety_margin, .fast_meter_period, .slow_meter_period, .canceller_bypass_threshold,
    .echo_safety_margin, .high_hybrid_detect_enable, .coeff_control_min_level,
    .double_talk_hangover, .double_talk_criterion, .speech_ctrl_config_4, .hangover_ms,
    .coeff_adapt_permit, .double_talk_allowed, .timer_expired
  );
  scct_host_model u_host (
    .pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .hung
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [3:0] s,
                    input logic e);
    logic [31:0] r;
    logic ge;
    u_host.xfer(1'b1, {i, 2'b00}, d, s, r, ge);
    chk($sformatf("write error %h", i), {31'h0, ge}, {31'h0, e});
  endtask
  task automatic rd(input logic [5:0] i, input logic [31:0] x, input logic e,
                    output logic [31:0] r);
    logic ge;
    u_host.xfer(1'b0, {i, 2'b00}, 32'h0, 4'h0, r, ge);
    chk($sformatf("read error %h", i), {31'h0, ge}, {31'h0, e});
    chk($sformatf("read data %h", i), r, x);
  endtask
  task automatic wait_exp(input int lo, input int hi);
    int n;
    n = 0;
    while (timer_expired !== 1'b1 && n <= hi) begin
      @(posedge pclk);
      n++;
    end
    if (n > hi) begin
      $display("[FAIL] expiry expected by %0d seen none", hi);
      err_total++;
      end_sim();
    end
    chk("expiry not early", {31'h0, n >= lo}, 32'h1);
  endtask

  always @(posedge pclk) begin
    if (hung === 1'b1) begin
      err_total++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, c1, c2;
    logic ge;
    err_total = 0;
    n_checks = 0;
    presetn = 1'b0;
    send_input_level = 5'h00;
    receive_input_level = 5'h00;
    transhybrid_loss_db = 7'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(ridx[k], {24'h0, rval[k]}, 1'b0, r);
    end
    $display("test reset values done");
    // locked writes, unmapped place, unlock, field routing
    wr(scct_pkg::IDX_CFG2, 32'h12, 4'hf, 1'b1);
    rd(scct_pkg::IDX_CFG2, 32'h97, 1'b0, r);
    wr(scct_pkg::IDX_CFG3, 32'h00, 4'hf, 1'b1);
    rd(scct_pkg::IDX_CFG3, 32'ha4, 1'b0, r);
    rd(6'h00, 32'h0, 1'b1, r);
    u_host.xfer(1'b0, {scct_pkg::IDX_CFG1, 2'b01}, 32'h0, 4'h0, r, ge);
    chk("misaligned error", {31'h0, ge}, 32'h1);
    chk("misaligned data", r, 32'h0);
    wr(scct_pkg::IDX_CTRL, 32'h02, 4'hf, 1'b0);
    wr(scct_pkg::IDX_CFG1, 32'ha5, 4'hf, 1'b0);
    wr(scct_pkg::IDX_CFG2, 32'h5a, 4'hf, 1'b0);
    wr(scct_pkg::IDX_CFG4, 32'h3c, 4'hf, 1'b0);
    wr(scct_pkg::IDX_CFG1, 32'h11, 4'he, 1'b0);
    rd(scct_pkg::IDX_CFG1, 32'ha5, 1'b0, r);
    chk("cfg1 fields", {24'h0, noise_safety_margin, fast_meter_period, slow_meter_period},
        32'ha5);
    chk("cfg2 fields", {24'h0, canceller_bypass_threshold, echo_safety_margin,
        high_hybrid_detect_enable}, 32'h5a);
    chk("cfg4 byte", {24'h0, speech_ctrl_config_4}, 32'h3c);
    $display("test protection done");
    foreach (rows[k]) begin
      wr(scct_pkg::IDX_CFG3, {24'h0, rows[k].cfg}, 4'hf, 1'b0);
      send_input_level <= rows[k].si;
      receive_input_level <= rows[k].ri;
      transhybrid_loss_db <= rows[k].loss;
      repeat (2) @(posedge pclk);
      chk("cfg3 fields", {24'h0, coeff_control_min_level, double_talk_hangover,
          double_talk_criterion}, {24'h0, rows[k].cfg});
      chk("adapt permit", {31'h0, coeff_adapt_permit}, {31'h0, rows[k].permit});
      chk("double talk", {31'h0, double_talk_allowed}, {31'h0, rows[k].allowed});
      chk("hangover", {23'h0, hangover_ms}, {23'h0, rows[k].hang});
    end
    $display("test level table done");
    // long countdown using both load bytes
    wr(scct_pkg::IDX_TIM_HI, 32'h01, 4'hf, 1'b0);
    wr(scct_pkg::IDX_TIM_LO, 32'h05, 4'hf, 1'b0);
    wr(scct_pkg::IDX_CTRL, 32'h03, 4'hf, 1'b0);
    wait_exp(261 * MSC, 262 * MSC + 2);
    repeat (3 * MSC) @(posedge pclk);
    rd(scct_pkg::IDX_COUNT, 32'h0, 1'b0, r);
    chk("expired held", {31'h0, timer_expired}, 32'h1);
    rd(scct_pkg::IDX_STATUS, 32'h1, 1'b0, r);
    wr(scct_pkg::IDX_COUNT, 32'hffff, 4'hf, 1'b0);
    rd(scct_pkg::IDX_COUNT, 32'h0, 1'b0, r);
    wr(scct_pkg::IDX_STATUS, 32'h01, 4'hf, 1'b0);
    @(posedge pclk);
    chk("expired cleared", {31'h0, timer_expired}, 32'h0);
    $display("test countdown done");
    // zero load expires at once
    wr(scct_pkg::IDX_CTRL, 32'h02, 4'hf, 1'b0);
    wr(scct_pkg::IDX_TIM_HI, 32'h00, 4'hf, 1'b0);
    wr(scct_pkg::IDX_TIM_LO, 32'h00, 4'hf, 1'b0);
    wr(scct_pkg::IDX_CTRL, 32'h03, 4'hf, 1'b0);
    wait_exp(0, 4);
    wr(scct_pkg::IDX_STATUS, 32'h01, 4'hf, 1'b0);
    $display("test zero load done");
    // stop freezes, restart reloads
    wr(scct_pkg::IDX_CTRL, 32'h02, 4'hf, 1'b0);
    wr(scct_pkg::IDX_TIM_LO, 32'h0a, 4'hf, 1'b0);
    wr(scct_pkg::IDX_CTRL, 32'h03, 4'hf, 1'b0);
    repeat (3 * MSC) @(posedge pclk);
    wr(scct_pkg::IDX_CTRL, 32'h02, 4'hf, 1'b0);
    u_host.xfer(1'b0, {scct_pkg::IDX_COUNT, 2'b00}, 32'h0, 4'h0, c1, ge);
    repeat (4 * MSC) @(posedge pclk);
    u_host.xfer(1'b0, {scct_pkg::IDX_COUNT, 2'b00}, 32'h0, 4'h0, c2, ge);
    chk("frozen count", c2, c1);
    chk("count stepped", {31'h0, c1 > 0 && c1 < 32'h0a}, 32'h1);
    chk("not expired", {31'h0, timer_expired}, 32'h0);
    wr(scct_pkg::IDX_CTRL, 32'h03, 4'hf, 1'b0);
    rd(scct_pkg::IDX_COUNT, 32'h0a, 1'b0, r);
    rd(scct_pkg::IDX_STATUS, 32'h2, 1'b0, r);
    $display("test stop and restart done");
    // reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset expired", {31'h0, timer_expired}, 32'h0);
    chk("reset cfg3", {24'h0, coeff_control_min_level, double_talk_hangover,
        double_talk_criterion}, 32'ha4);
    chk("reset cfg1", {24'h0, noise_safety_margin, fast_meter_period, slow_meter_period},
        32'h69);
    presetn <= 1'b1;
    rd(scct_pkg::IDX_COUNT, 32'h0, 1'b0, r);
    rd(scct_pkg::IDX_CTRL, 32'h0, 1'b0, r);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
